//--- vrcc_defines.svh
// register offsets, field positions and reset values of the vc0 resource registers
`ifndef VRCC_DEFINES_SVH
`define VRCC_DEFINES_SVH
`define VRCC_CAP_OFFSET 12'h150
`define VRCC_CTRL_OFFSET 12'h154
`define VRCC_CAP_ARB_RESET 8'h09
`define VRCC_CAP_SLOTS_RESET 7'h7F
`define VRCC_CAP_TABLE_RESET 8'h04
`define VRCC_MAP_RESET 8'hFF
`define VRCC_SEL_RESET 3'h0
`define VRCC_SEL_WRR 3'h3
`define VRCC_ID_RESET 3'h0
`define VRCC_EN_RESET 1'h1
`define VRCC_MAP_LSB 0
`define VRCC_LOAD_BIT 16
`define VRCC_SEL_LSB 17
`define VRCC_ID_LSB 24
`define VRCC_EN_BIT 31
`define VRCC_SLOTS_LSB 16
`define VRCC_TABLE_LSB 24
`define VRCC_LOAD_CYCLES 4'h8
`endif

//--- vrcc_pkg.sv
// types of the vc0 resource register bank
package vrcc_pkg;
  typedef enum logic [1:0] {
    VRCC_IDLE = 2'h0,
    VRCC_LOAD = 2'h1
  } vrcc_load_state_type;
  typedef struct packed {
    logic [7:0] trafficClassChannelMap;
    logic [2:0] arbSelect;
    logic channelEnable;
    logic [6:0] maxTimeSlots;
    logic tableStatus;
    vrcc_load_state_type loadState;
    logic [3:0] loadCount;
    logic tableApply;
    logic [31:0] prdata;
  } vrcc_state_type;
endpackage

//--- vrcc_regs.sv
// vc0 resource capability and control registers behind an apb slave
//
// What this block does
// [RULE_01] Capability bits 7:0 read 09h: round robin and 128-phase weighted arbitration.
// [RULE_02] Time-based weighted round robin is never a valid scheme for this channel.
// [RULE_03] Capability bit 14 reads 0: not limited to optimized packet switching traffic.
// [RULE_04] Capability bit 15, snoop rejection, always reads 0.
// [RULE_05] Capability bits 22:16 give time slots minus one, 7Fh unless autoloaded.
// [RULE_06] Capability bits 31:24 give the table location in sixteen_byte_unit, 04h.
// [RULE_07] Control bits 7:0 are the writable class map, FFh unless autoloaded.
// [RULE_08] Writing 1 to control bit 16 applies the table; the bit reads 0.
// [RULE_09] Scheme select bits 19:17 accept 000b or 011b; others act as 000b.
// [RULE_10] Control bits 26:24 read the channel identifier 000b.
// [RULE_11] Control bit 31 enables the channel; writing 0 disables it.
// [RULE_12] A table entry write sets the table status; load completion clears it.
// [RULE_13] Reserved bits read 0 and ignore writes.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "vrcc_defines.svh"

module vrcc_regs (
  input wire logic clk, // core clock, 25 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic autoloadValid, // eeprom autoload strobe
  input wire logic [7:0] autoloadMap, // autoloaded class map
  input wire logic [6:0] autoloadSlots, // autoloaded time slots
  input wire logic tableEntryWrite, // software wrote an arbitration table entry
  output logic [7:0] trafficClassChannelMap, // class map to the switch
  output logic [2:0] arbSelect, // effective arbitration scheme
  output logic channelEnable, // channel enable
  output logic tableApply, // pulse: apply table to arbiter
  output logic tableStatus // table written, not yet loaded
);

  // ****************************************
  // state
  // ****************************************
  vrcc_pkg::vrcc_state_type state;
  vrcc_pkg::vrcc_state_type next_state;
  logic access;
  logic setupRead;
  logic hitCap;
  logic hitCtrl;
  logic ctrlWrite;
  logic [31:0] capWord;
  logic [31:0] ctrlWord;

  assign access = psel && penable;
  assign setupRead = psel && !penable && !pwrite;
  assign hitCap = paddr == `VRCC_CAP_OFFSET;
  assign hitCtrl = paddr == `VRCC_CTRL_OFFSET;
  assign ctrlWrite = access && pwrite && hitCtrl;
  assign pready = 1'b1;
  assign pslverr = access && !(hitCap || hitCtrl);

  // ****************************************
  // read words
  // ****************************************
  always_comb begin
    capWord = 32'h0; // [RULE_13]
    capWord[7:0] = `VRCC_CAP_ARB_RESET; // [RULE_01]
    capWord[14] = 1'b0; // [RULE_03]
    capWord[15] = 1'b0; // [RULE_04]
    capWord[`VRCC_SLOTS_LSB +: 7] = state.maxTimeSlots; // [RULE_05]
    capWord[`VRCC_TABLE_LSB +: 8] = `VRCC_CAP_TABLE_RESET; // [RULE_06]
    ctrlWord = 32'h0; // [RULE_13]
    ctrlWord[`VRCC_MAP_LSB +: 8] = state.trafficClassChannelMap;
    ctrlWord[`VRCC_LOAD_BIT] = 1'b0; // [RULE_08]
    ctrlWord[`VRCC_SEL_LSB +: 3] = state.arbSelect;
    ctrlWord[`VRCC_ID_LSB +: 3] = `VRCC_ID_RESET; // [RULE_10]
    ctrlWord[`VRCC_EN_BIT] = state.channelEnable;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.tableApply = 1'b0;
    if (autoloadValid) begin
      next_state.trafficClassChannelMap = autoloadMap; // [RULE_07]
      next_state.maxTimeSlots = autoloadSlots; // [RULE_05]
    end
    if (ctrlWrite) begin
      next_state.trafficClassChannelMap = pwdata[`VRCC_MAP_LSB +: 8]; // [RULE_07]
      next_state.channelEnable = pwdata[`VRCC_EN_BIT]; // [RULE_11]
      // only 000b and 011b are kept; time-based schemes fall back to default
      if (pwdata[`VRCC_SEL_LSB +: 3] == `VRCC_SEL_WRR) begin
        next_state.arbSelect = `VRCC_SEL_WRR; // [RULE_09]
      end else begin
        next_state.arbSelect = `VRCC_SEL_RESET; // [RULE_02] [RULE_09]
      end
    end
    case (state.loadState)
      vrcc_pkg::VRCC_IDLE: begin
        if (ctrlWrite && pwdata[`VRCC_LOAD_BIT]) begin
          next_state.loadState = vrcc_pkg::VRCC_LOAD; // [RULE_08]
          next_state.loadCount = `VRCC_LOAD_CYCLES;
        end
      end
      vrcc_pkg::VRCC_LOAD: begin
        next_state.loadCount = state.loadCount - 4'h1;
        if (state.loadCount == 4'h1) begin
          next_state.loadState = vrcc_pkg::VRCC_IDLE;
          next_state.tableApply = 1'b1; // [RULE_08]
          next_state.tableStatus = 1'b0; // [RULE_12]
        end
      end
      default: begin
        next_state.loadState = vrcc_pkg::VRCC_IDLE;
      end
    endcase
    // a new entry write wins over the completion clear
    if (tableEntryWrite) begin
      next_state.tableStatus = 1'b1; // [RULE_12]
    end
    // read word taken at the end of the setup cycle, so prdata leaves a flip-flop
    if (setupRead) begin
      next_state.prdata = hitCap ? capWord : (hitCtrl ? ctrlWord : 32'h0); // [RULE_13]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state.trafficClassChannelMap <= `VRCC_MAP_RESET;
      state.arbSelect <= `VRCC_SEL_RESET;
      state.channelEnable <= `VRCC_EN_RESET;
      state.maxTimeSlots <= `VRCC_CAP_SLOTS_RESET;
      state.tableStatus <= 1'b0;
      state.loadState <= vrcc_pkg::VRCC_IDLE;
      state.loadCount <= 4'h0;
      state.tableApply <= 1'b0;
      state.prdata <= 32'h0;
    end else begin
      state <= next_state;
    end
  end

  // holds the last read word; valid through the whole access phase
  assign prdata = state.prdata;
  assign trafficClassChannelMap = state.trafficClassChannelMap;
  assign arbSelect = state.arbSelect;
  assign channelEnable = state.channelEnable;
  assign tableApply = state.tableApply;
  assign tableStatus = state.tableStatus;

  // ****************************************
  // checks
  // ****************************************
  chk_cap_read: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_01]
    (access && !pwrite && hitCap) |-> (prdata[15:0] == 16'h0009 && prdata[31:24] == 8'h04))
    else $error("capability word wrong");
  chk_load_readzero: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_08]
    (access && !pwrite && hitCtrl) |-> !prdata[16])
    else $error("load bit read back set");
  chk_load_apply: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_08]
    (ctrlWrite && pwdata[16] && state.loadState == vrcc_pkg::VRCC_IDLE)
    |=> ##8 tableApply)
    else $error("table not applied after the load time");
  chk_sel_legal: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_09]
    (arbSelect == 3'h0 || arbSelect == 3'h3))
    else $error("illegal arbitration scheme held");
  chk_sel_fold: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_02]
    (ctrlWrite && pwdata[19:17] == 3'h4) |=> arbSelect == 3'h0)
    else $error("time based scheme accepted");
  chk_map_write: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_07]
    ctrlWrite |=> trafficClassChannelMap == $past(pwdata[7:0]))
    else $error("class map not written");
  chk_enable_write: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_11]
    (ctrlWrite && !pwdata[31]) |=> !channelEnable)
    else $error("channel not disabled");
  chk_status_set: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_12]
    tableEntryWrite |=> tableStatus)
    else $error("table status not set");
  chk_status_clear: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_12]
    (tableApply && !$past(tableEntryWrite)) |-> !tableStatus)
    else $error("table status not cleared");
  chk_ctrl_rsvd: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_13]
    (access && !pwrite && hitCtrl) |-> (prdata[15:8] == 8'h0 && prdata[30:27] == 4'h0
      && prdata[23:20] == 4'h0 && prdata[26:24] == 3'h0))
    else $error("reserved control bits nonzero");

  // ****************************************
  // checks: capability word and unmapped access
  // ****************************************
  chk_cap_fixed: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_03] [RULE_04]
    (access && !pwrite && hitCap)
    |-> (prdata[14] == 1'b0 && prdata[15] == 1'b0))
    else $error("capability bits 15:14 not zero");
  chk_cap_rsvd: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_13]
    (access && !pwrite && hitCap)
    |-> (prdata[13:8] == 6'h00 && prdata[23] == 1'b0))
    else $error("reserved capability bits nonzero");
  chk_cap_table: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_06]
    (access && !pwrite && hitCap)
    |-> (prdata[31:24] == 8'h04))
    else $error("table location wrong");
  chk_slots_load: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_05]
    autoloadValid
    |=> (state.maxTimeSlots == $past(autoloadSlots)))
    else $error("time slots not autoloaded");
  chk_slots_hold: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_05]
    !autoloadValid
    |=> $stable(state.maxTimeSlots))
    else $error("time slots changed without autoload");
  chk_addr_error: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_13]
    (access && paddr != `VRCC_CAP_OFFSET && paddr != `VRCC_CTRL_OFFSET)
    |-> (pslverr && (pwrite || prdata == 32'h0)))
    else $error("unmapped access not refused");

  // ****************************************
  // checks: control word
  // ****************************************
  chk_map_autoload: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_07]
    (autoloadValid && !ctrlWrite)
    |=> (trafficClassChannelMap == $past(autoloadMap)))
    else $error("class map not autoloaded");
  chk_map_hold: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_07]
    (!autoloadValid && !ctrlWrite)
    |=> $stable(trafficClassChannelMap))
    else $error("class map changed without a write");
  chk_sel_keep: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_09]
    (ctrlWrite && pwdata[19:17] == 3'h3)
    |=> (arbSelect == 3'h3))
    else $error("weighted scheme not kept");
  chk_sel_hold: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_09]
    !ctrlWrite
    |=> $stable(arbSelect))
    else $error("scheme changed without a write");
  chk_enable_set: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_11]
    (ctrlWrite && pwdata[31])
    |=> channelEnable)
    else $error("channel not enabled");
  chk_ctrl_enable: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_11]
    (access && !pwrite && hitCtrl)
    |-> (prdata[31] == channelEnable))
    else $error("enable bit read back wrong");
  chk_ctrl_select: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_09]
    (access && !pwrite && hitCtrl)
    |-> (prdata[19:17] == arbSelect))
    else $error("scheme read back wrong");

  // ****************************************
  // checks: table load
  // ****************************************
  chk_load_start: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_08]
    (ctrlWrite && pwdata[16] && state.loadState == vrcc_pkg::VRCC_IDLE)
    |=> (state.loadState == vrcc_pkg::VRCC_LOAD && state.loadCount == `VRCC_LOAD_CYCLES))
    else $error("table load not started");
  chk_load_step: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_08]
    (state.loadState == vrcc_pkg::VRCC_LOAD && state.loadCount != 4'h1)
    |=> (state.loadState == vrcc_pkg::VRCC_LOAD && state.loadCount == $past(state.loadCount) - 4'h1))
    else $error("table load count skipped");
  chk_load_busy: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_08]
    (state.loadState == vrcc_pkg::VRCC_LOAD)
    |-> (state.loadCount != 4'h0 && state.loadCount <= `VRCC_LOAD_CYCLES))
    else $error("table load count out of range");
  chk_apply_pulse: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_08]
    tableApply
    |=> !tableApply)
    else $error("apply pulse longer than one cycle");
  chk_status_hold: assert property (@(posedge clk) disable iff (!arst_n) // [RULE_12]
    (!tableEntryWrite && !(state.loadState == vrcc_pkg::VRCC_LOAD && state.loadCount == 4'h1))
    |=> $stable(tableStatus))
    else $error("table status changed without cause");

  // ****************************************
  // cover points
  // ****************************************
  cov_load: cover property (@(posedge clk) disable iff (!arst_n) tableApply);
  cov_disable: cover property (@(posedge clk) disable iff (!arst_n) $fell(channelEnable));
  cov_wrr: cover property (@(posedge clk) disable iff (!arst_n) arbSelect == 3'h3);
  cov_unmapped: cover property (@(posedge clk) disable iff (!arst_n) pslverr);
  cov_fold: cover property (@(posedge clk) disable iff (!arst_n) ctrlWrite && pwdata[19:17] == 3'h4);

endmodule // vrcc_regs

//--- vrcc_regs_test.sv
// self-checking testbench of the vc0 resource register bank
`timescale 1ns/1ps
`include "vrcc_defines.svh"

module vrcc_regs_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic autoloadValid = 1'b0;
  logic [7:0] autoloadMap = 8'h00;
  logic [6:0] autoloadSlots = 7'h00;
  logic tableEntryWrite = 1'b0;
  logic [7:0] trafficClassChannelMap;
  logic [2:0] arbSelect;
  logic channelEnable;
  logic tableApply;
  logic tableStatus;
  logic [31:0] rd;
  logic err;
  int nMismatch = 0;
  int comparisons = 0;
  int k;
  int waits = 0;

  vrcc_regs i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .autoloadValid(autoloadValid), .autoloadMap(autoloadMap), .autoloadSlots(autoloadSlots),
    .tableEntryWrite(tableEntryWrite), .trafficClassChannelMap(trafficClassChannelMap),
    .arbSelect(arbSelect), .channelEnable(channelEnable), .tableApply(tableApply),
    .tableStatus(tableStatus));

  always #20 clk = ~clk;

  // ****************************************************************
  // bus cycle, compare and closing tasks
  // ****************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      nMismatch++;
      $display("[ERR] %0t bus transfer timed out", $time);
      end_of_test;
    end else begin
      waits = n - 1;
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 4000);
    nMismatch++;
    end_of_test;
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h150, 32'h0);
    chk(rd, 32'h047F0009, "cap reset");
    chk(32'(waits), 32'h0, "cap read wait states");
    apb(1'b0, 12'h154, 32'h0);
    chk(rd, 32'h800000FF, "ctrl reset");
    apb(1'b1, 12'h150, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h0, "cap write no error");
    apb(1'b0, 12'h150, 32'h0);
    chk(rd, 32'h047F0009, "cap write ignored");
    apb(1'b1, 12'h158, 32'h00000000);
    chk({31'h0, err}, 32'h1, "unmapped write error");
    apb(1'b0, 12'h158, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    $display("test reset and map done");
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 12'h154, {1'b1, 7'h7F, 4'hF, 3'(s), 1'b0, 8'hFF, 8'hA5});
      apb(1'b0, 12'h154, 32'h0);
      chk(rd, {1'b1, 11'h0, (s == 3) ? 3'h3 : 3'h0, 9'h0, 8'hA5}, "select");
      chk({29'h0, arbSelect}, (s == 3) ? 32'h3 : 32'h0, "select port");
    end
    apb(1'b1, 12'h154, 32'h0000003C);
    @(posedge clk);
    chk({23'h0, channelEnable, trafficClassChannelMap}, 32'h3C, "disable");
    $display("test select and enable done");
    @(posedge clk);
    tableEntryWrite <= 1'b1;
    @(posedge clk);
    tableEntryWrite <= 1'b0;
    @(posedge clk);
    chk({31'h0, tableStatus}, 32'h1, "status set");
    apb(1'b1, 12'h154, 32'h80010081);
    k = 0;
    // the pulse is launched by the last count edge and seen at the edge after it
    while (tableApply !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k), 32'(`VRCC_LOAD_CYCLES) + 32'h1, "apply delay");
    chk({31'h0, tableStatus}, 32'h0, "status cleared");
    apb(1'b0, 12'h154, 32'h0);
    chk(rd, 32'h80000081, "load bit reads 0");
    $display("test table load done");
    @(posedge clk);
    autoloadMap <= 8'h5C;
    autoloadSlots <= 7'h12;
    autoloadValid <= 1'b1;
    @(posedge clk);
    autoloadValid <= 1'b0;
    apb(1'b0, 12'h150, 32'h0);
    chk(rd, 32'h04120009, "autoload slots");
    apb(1'b0, 12'h154, 32'h0);
    chk(rd, 32'h8000005C, "autoload map");
    $display("test autoload done");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h150, 32'h0);
    chk(rd, 32'h047F0009, "cap after reset");
    apb(1'b0, 12'h154, 32'h0);
    chk(rd, 32'h800000FF, "ctrl after reset");
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule // vrcc_regs_test
